/* hw/fault_pkg.sv */
// Notes on behaviour
// [RULE_01] supply lockout: fault low, switches and relays off
// [RULE_02] power good needs low drop, no limit, no open
// [RULE_03] low current past 25.6 ms turns switch off
// [RULE_04] open turn-off drives fault low, sets flag
// [RULE_05] request low clears open latch, fault, flag
// [RULE_06] select high: status high when fully on
// [RULE_07] select high: status low in limit or drop
// [RULE_08] select low: status shows open latch if enabled
// [RULE_09] select low: status low when current good
// [RULE_10] limit beyond timeout latches switch off
// [RULE_11] overcurrent latch drops power good, asserts fault
// [RULE_12] retry: off for off-time, then back on
// [RULE_13] no retry: stay off, fault until cleared
// [RULE_14] request low clears overcurrent latch and fault
// [RULE_15] timeout is 6.4 ms times 1 to 20
// [RULE_16] duty select gives 99, 49, 24 timeouts off
// [RULE_17] open detector armed 900 ms after power good
// [RULE_18] retry enable input picks retry or latch
// [RULE_19] select picks power good or open status
// [RULE_20] all counters per port on one shared tick
package fault_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_US = 100;
    localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int OPEN_DELAY_US = 25_600;
    localparam int ARM_DELAY_US = 900_000;
    localparam int TIMEOUT_UNIT_US = 6_400;
    localparam int CNT_W = 17;
    localparam logic [CNT_W-1:0] OPEN_TICKS = CNT_W'(OPEN_DELAY_US / TICK_US);
    localparam logic [CNT_W-1:0] ARM_TICKS = CNT_W'(ARM_DELAY_US / TICK_US);
    localparam logic [CNT_W-1:0] UNIT_TICKS = CNT_W'(TIMEOUT_UNIT_US / TICK_US);
    localparam logic [4:0] MULT_MIN = 5'h01;
    localparam logic [4:0] MULT_MAX = 5'h14;
    localparam logic [1:0] DUTY_ZERO = 2'h0;
    localparam logic [1:0] DUTY_ONE = 2'h1;
    localparam logic [1:0] DUTY_OPEN = 2'h2;
    localparam logic [CNT_W-1:0] OFF_MULT_ZERO = 17'h0_0063;
    localparam logic [CNT_W-1:0] OFF_MULT_ONE = 17'h0_0031;
    localparam logic [CNT_W-1:0] OFF_MULT_OPEN = 17'h0_0018;
    // register map, byte addresses
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RETRY_BIT = 1;
    localparam int CTRL_SEL_BIT = 2;
    localparam int CTRL_DUTY_LSB = 3;
    localparam int CTRL_MULT_LSB = 8;

    typedef enum logic [2:0] {CH_OFF, CH_ON, CH_RETRY, CH_LATCH, CH_COOL, CH_OPEN} chan_st_t;

    typedef struct packed {
        logic open_detect_enable;
        logic retry_enable;
        logic status_source_select;
        logic [1:0] duty_select;
        logic [4:0] timeout_mult;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b1, DUTY_ZERO, MULT_MIN};

    typedef struct packed {
        logic request;
        logic relay_on;
        logic overcurrent;
        logic undercurrent;
        logic drop_high;
    } port_in_t;

    typedef struct packed {
        logic switch_on;
        logic power_good_status;
        logic port_open_flag;
        logic oc_latch;
    } port_out_t;
endpackage

/* hw/port_channel.sv */
`timescale 1ns/1ps
module port_channel (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic tick_i,
    input wire logic lock_i,
    input wire fault_pkg::ctrl_t ctrl_i,
    input wire logic [fault_pkg::CNT_W-1:0] timeout_ticks_i,
    input wire logic [fault_pkg::CNT_W-1:0] off_ticks_i,
    input wire fault_pkg::port_in_t pin_i,
    output fault_pkg::port_out_t pout_o
);
    typedef struct packed {
        fault_pkg::chan_st_t st;
        logic [fault_pkg::CNT_W-1:0] oc_cnt;
        logic [fault_pkg::CNT_W-1:0] low_cnt;
        logic [fault_pkg::CNT_W-1:0] arm_cnt;
        logic [fault_pkg::CNT_W-1:0] off_cnt;
        logic armed;
        logic oc_latch;
        logic open_flag;
    } chan_state_t;

    chan_state_t r, nxt;
    logic good_cond;
    logic off_done;

    always_comb begin
        nxt = r;
        good_cond = (r.st == fault_pkg::CH_ON) && !lock_i && !pin_i.drop_high
            && !pin_i.overcurrent;
        off_done = (r.off_cnt >= off_ticks_i);
        if (tick_i && !off_done && r.st inside {fault_pkg::CH_RETRY, fault_pkg::CH_LATCH,
            fault_pkg::CH_COOL}) begin
            nxt.off_cnt = r.off_cnt + 1'b1;
        end
        if (lock_i) begin
            nxt = '0; // [RULE_01]
            nxt.st = fault_pkg::CH_OFF;
        end else begin
            unique case (r.st)
                fault_pkg::CH_OFF: begin
                    if (pin_i.request && pin_i.relay_on) begin
                        nxt.st = fault_pkg::CH_ON;
                        nxt.oc_cnt = '0;
                        nxt.low_cnt = '0;
                        nxt.arm_cnt = '0;
                        nxt.armed = 1'b0;
                    end
                end
                fault_pkg::CH_ON: begin
                    if (!pin_i.request || !pin_i.relay_on) begin
                        nxt.st = fault_pkg::CH_OFF;
                    end else if (pin_i.overcurrent) begin
                        if (tick_i) begin
                            nxt.oc_cnt = r.oc_cnt + 1'b1; // [RULE_20]
                        end
                        if (r.oc_cnt >= timeout_ticks_i) begin
                            nxt.oc_latch = 1'b1; // [RULE_10]
                            nxt.off_cnt = '0;
                            nxt.st = ctrl_i.retry_enable ? fault_pkg::CH_RETRY
                                : fault_pkg::CH_LATCH; // [RULE_18]
                        end
                    end else begin
                        nxt.oc_cnt = '0;
                        if (!good_cond) begin
                            nxt.arm_cnt = '0;
                        end else if (!r.armed && tick_i) begin
                            nxt.arm_cnt = r.arm_cnt + 1'b1;
                        end
                        if (good_cond && r.arm_cnt >= fault_pkg::ARM_TICKS) begin
                            nxt.armed = 1'b1; // [RULE_17]
                        end
                        if (r.armed && ctrl_i.open_detect_enable && pin_i.undercurrent) begin
                            if (tick_i) begin
                                nxt.low_cnt = r.low_cnt + 1'b1;
                            end
                            if (r.low_cnt >= fault_pkg::OPEN_TICKS) begin
                                nxt.st = fault_pkg::CH_OPEN; // [RULE_03]
                                nxt.open_flag = 1'b1; // [RULE_04]
                            end
                        end else begin
                            nxt.low_cnt = '0;
                        end
                    end
                end
                fault_pkg::CH_RETRY: begin
                    if (!pin_i.request) begin
                        nxt.oc_latch = 1'b0; // [RULE_14]
                    end
                    if (off_done) begin
                        nxt.oc_latch = 1'b0; // [RULE_12]
                        nxt.oc_cnt = '0;
                        nxt.low_cnt = '0;
                        nxt.arm_cnt = '0;
                        nxt.armed = 1'b0;
                        nxt.st = (pin_i.request && pin_i.relay_on) ? fault_pkg::CH_ON
                            : fault_pkg::CH_OFF;
                    end
                end
                fault_pkg::CH_LATCH: begin
                    if (!pin_i.request) begin
                        nxt.oc_latch = 1'b0; // [RULE_13] [RULE_14]
                        nxt.st = fault_pkg::CH_COOL;
                    end
                end
                fault_pkg::CH_COOL: begin
                    if (off_done) begin
                        nxt.st = fault_pkg::CH_OFF;
                    end
                end
                fault_pkg::CH_OPEN: begin
                    if (!pin_i.request) begin
                        nxt.open_flag = 1'b0; // [RULE_05]
                        nxt.st = fault_pkg::CH_OFF;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign pout_o.switch_on = (r.st == fault_pkg::CH_ON) && !lock_i;
    assign pout_o.power_good_status = good_cond && !r.open_flag; // [RULE_02] [RULE_11]
    assign pout_o.port_open_flag = r.open_flag;
    assign pout_o.oc_latch = r.oc_latch;
endmodule

/* hw/quad_port_fault_manager.sv */
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module quad_port_fault_manager #(
    parameter int TICK_CYCLES = fault_pkg::TICK_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic supply_low_lockout_i,
    input wire logic [3:0] switch_request_i,
    input wire logic [3:0] relay_request_i,
    input wire logic [3:0] current_limit_i,
    input wire logic [3:0] low_current_i,
    input wire logic [3:0] drop_high_i,
    output logic fault_n_o,
    output logic [3:0] status_o,
    output logic [3:0] switch_on_o,
    output logic [3:0] relay_on_o
);
    localparam int PIN_W = 21;

    typedef struct packed {
        logic [PIN_W-1:0] pin_s1;
        logic [PIN_W-1:0] pin_s2;
        fault_pkg::ctrl_t ctrl;
        logic [15:0] tick_cnt;
        logic tick;
        logic waitreq;
        logic [31:0] rdata;
        logic fault_n;
        logic [3:0] status;
        logic [3:0] switch_on;
        logic [3:0] relay_on;
    } top_state_t;

    top_state_t r, nxt;
    fault_pkg::port_in_t [3:0] pin_w;
    fault_pkg::port_out_t [3:0] pout_w;
    logic lock;
    logic [3:0] req_s, relay_s, oc_s, under_s, drop_s;
    logic [3:0] pg_w, open_w, ocl_w, sw_w;
    logic [fault_pkg::CNT_W-1:0] timeout_ticks;
    logic [fault_pkg::CNT_W-1:0] off_ticks;
    logic [fault_pkg::CNT_W-1:0] off_mult;
    logic [4:0] wr_mult;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;

    assign {lock, drop_s, under_s, oc_s, relay_s, req_s} = r.pin_s2;

    always_comb begin
        unique case (r.ctrl.duty_select)
            fault_pkg::DUTY_ZERO: off_mult = fault_pkg::OFF_MULT_ZERO; // [RULE_16]
            fault_pkg::DUTY_ONE: off_mult = fault_pkg::OFF_MULT_ONE;
            default: off_mult = fault_pkg::OFF_MULT_OPEN;
        endcase
    end

    assign timeout_ticks = fault_pkg::CNT_W'(r.ctrl.timeout_mult) * fault_pkg::UNIT_TICKS;
    assign off_ticks = fault_pkg::CNT_W'(timeout_ticks * off_mult);

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_port
            assign pin_w[g] = '{req_s[g], relay_s[g], oc_s[g], under_s[g], drop_s[g]};
            port_channel u_chan (
                .sys_clk_i(sys_clk_i),
                .reset_n_i(reset_n_i),
                .tick_i(r.tick),
                .lock_i(lock),
                .ctrl_i(r.ctrl),
                .timeout_ticks_i(timeout_ticks),
                .off_ticks_i(off_ticks),
                .pin_i(pin_w[g]),
                .pout_o(pout_w[g])
            ); // [RULE_20]
            assign pg_w[g] = pout_w[g].power_good_status;
            assign open_w[g] = pout_w[g].port_open_flag;
            assign ocl_w[g] = pout_w[g].oc_latch;
            assign sw_w[g] = pout_w[g].switch_on;
        end
    endgenerate

    assign ctrl_word = {19'h0_0000, r.ctrl.timeout_mult, 3'h0, r.ctrl.duty_select,
        r.ctrl.status_source_select, r.ctrl.retry_enable, r.ctrl.open_detect_enable};
    assign status_word = {14'h0000, ~r.fault_n, lock, sw_w, ocl_w, open_w, pg_w};

    always_comb begin
        nxt = r;
        nxt.pin_s1 = {supply_low_lockout_i, drop_high_i, low_current_i, current_limit_i,
            relay_request_i, switch_request_i};
        nxt.pin_s2 = r.pin_s1;
        nxt.tick = 1'b0;
        if (r.tick_cnt >= 16'(TICK_CYCLES - 1)) begin
            nxt.tick_cnt = '0;
            nxt.tick = 1'b1;
        end else begin
            nxt.tick_cnt = r.tick_cnt + 1'b1;
        end
        wr_mult = avs_writedata_i[fault_pkg::CTRL_MULT_LSB +: 5];
        nxt.waitreq = !((avs_read_i || avs_write_i) && r.waitreq);
        if (avs_read_i && r.waitreq) begin
            unique case (avs_address_i)
                fault_pkg::CTRL_ADDR: nxt.rdata = ctrl_word;
                fault_pkg::STATUS_ADDR: nxt.rdata = status_word;
                default: nxt.rdata = '0;
            endcase
        end
        if (avs_write_i && !r.waitreq && avs_address_i == fault_pkg::CTRL_ADDR) begin
            if (avs_byteenable_i[0]) begin
                nxt.ctrl.open_detect_enable = avs_writedata_i[fault_pkg::CTRL_EN_BIT];
                nxt.ctrl.retry_enable = avs_writedata_i[fault_pkg::CTRL_RETRY_BIT];
                nxt.ctrl.status_source_select = avs_writedata_i[fault_pkg::CTRL_SEL_BIT];
                nxt.ctrl.duty_select = avs_writedata_i[fault_pkg::CTRL_DUTY_LSB +: 2];
            end
            if (avs_byteenable_i[1]) begin
                if (wr_mult < fault_pkg::MULT_MIN) begin
                    nxt.ctrl.timeout_mult = fault_pkg::MULT_MIN; // [RULE_15]
                end else if (wr_mult > fault_pkg::MULT_MAX) begin
                    nxt.ctrl.timeout_mult = fault_pkg::MULT_MAX;
                end else begin
                    nxt.ctrl.timeout_mult = wr_mult;
                end
            end
        end
        nxt.fault_n = !(lock || (|ocl_w) || (|open_w)); // [RULE_01] [RULE_04] [RULE_11]
        if (r.ctrl.status_source_select) begin
            nxt.status = pg_w; // [RULE_06] [RULE_07] [RULE_19]
        end else begin
            nxt.status = open_w & {4{r.ctrl.open_detect_enable}}; // [RULE_08] [RULE_09]
        end
        nxt.switch_on = sw_w;
        nxt.relay_on = relay_s & {4{!lock}}; // [RULE_01]
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            r <= '0;
            r.ctrl <= fault_pkg::CTRL_RESET;
            r.waitreq <= 1'b1;
            r.fault_n <= 1'b1;
        end else begin
            r <= nxt;
        end
    end

    assign avs_readdata_o = r.rdata;
    assign avs_waitrequest_o = r.waitreq;
    assign fault_n_o = r.fault_n;
    assign status_o = r.status;
    assign switch_on_o = r.switch_on;
    assign relay_on_o = r.relay_on;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_lockout_off;
        lock |=> !fault_n_o && switch_on_o == 4'h0 && relay_on_o == 4'h0;
    endproperty
    a_lockout_off: assert property (p_lockout_off) else $error("lockout left on"); // [RULE_01]

    property p_pg_cond;
        (pg_w & (oc_s | drop_s | open_w)) == 4'h0;
    endproperty
    a_pg_cond: assert property (p_pg_cond) else $error("power good while bad"); // [RULE_02]

    // watched on every port, so the one port the bench opens is covered
    property p_open_fault;
        (open_w & ~$past(open_w)) != 4'h0 |=> !fault_n_o;
    endproperty
    a_open_fault: assert property (p_open_fault) else $error("open latch, no fault"); // [RULE_04]

    property p_open_clear;
        (open_w & ~req_s) != 4'h0 && !lock
            |=> ($past(open_w & ~req_s) & (open_w | switch_on_o)) == 4'h0;
    endproperty
    a_open_clear: assert property (p_open_clear) else $error("open not cleared"); // [RULE_05]

    property p_stat_pg;
        r.ctrl.status_source_select |=> status_o == $past(pg_w);
    endproperty
    a_stat_pg: assert property (p_stat_pg) else $error("status not power good"); // [RULE_19]

    property p_stat_limit;
        r.ctrl.status_source_select && (oc_s | drop_s) != 4'h0
            |=> (status_o & $past(oc_s | drop_s)) == 4'h0;
    endproperty
    a_stat_limit: assert property (p_stat_limit) else $error("status high in limit"); // [RULE_07]

    property p_stat_disabled;
        !r.ctrl.status_source_select && !r.ctrl.open_detect_enable |=> status_o == 4'h0;
    endproperty
    a_stat_disabled: assert property (p_stat_disabled) else $error("disabled status"); // [RULE_08]

    property p_oc_cause;
        $rose(ocl_w[0]) |-> $past(oc_s[0]) ##1 !fault_n_o;
    endproperty
    a_oc_cause: assert property (p_oc_cause) else $error("latch without limit"); // [RULE_11]

    property p_no_retry_hold;
        ocl_w[0] && !r.ctrl.retry_enable && req_s[0] && !lock |=> ocl_w[0] && !sw_w[0];
    endproperty
    a_no_retry_hold: assert property (p_no_retry_hold) else $error("latch let go"); // [RULE_13]

    property p_bus_answer;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    c_oc_latch: cover property ($rose(ocl_w[0]));
    c_open_latch: cover property ($rose(|open_w));
    c_retry_back_on: cover property ($fell(ocl_w[3]) ##[1:3] sw_w[3]);
    c_ctrl_write: cover property (avs_write_i && !avs_waitrequest_o);
endmodule

/* tb/host_ctrl_model.sv */
`timescale 1ns/1ps
module host_ctrl_model (
    input wire logic sys_clk_i,
    input wire logic slow_i,
    input wire logic [3:0] on_cmd_i,
    input wire logic [3:0] relay_cmd_i,
    output logic [3:0] switch_request_o,
    output logic [3:0] relay_request_o
);
    logic [3:0] on_d_r = 4'h0;
    logic [3:0] rly_d_r = 4'h0;
    initial begin
        switch_request_o = 4'h0;
        relay_request_o = 4'h0;
    end
    // slow mode answers a cycle late; a switch is only requested behind its relay
    always @(posedge sys_clk_i) begin
        on_d_r <= on_cmd_i;
        rly_d_r <= relay_cmd_i;
        relay_request_o <= slow_i ? rly_d_r : relay_cmd_i;
        // dropping a request is how a latched port is cleared
        switch_request_o <= (slow_i ? on_d_r : on_cmd_i) & relay_request_o;
    end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int TICKS = 2;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic supply_low_lockout_i = 1'b0;
    logic [3:0] current_limit_i = 4'h0;
    logic [3:0] low_current_i = 4'h0;
    logic [3:0] drop_high_i = 4'h0;
    logic [3:0] on_cmd = 4'h0;
    logic [3:0] relay_cmd = 4'h0;
    logic slow = 1'b0;
    logic [3:0] switch_request;
    logic [3:0] relay_request;
    logic fault_n_o;
    logic [3:0] status_o;
    logic [3:0] switch_on_o;
    logic [3:0] relay_on_o;
    int miscompares = 0;
    int n_tests = 0;
    int n;
    logic [31:0] rd;
    typedef struct packed {
        logic [31:0] c;
        logic [3:0] drop;
        logic [3:0] lim;
        logic [3:0] st;
    } row_t;
    row_t rows [6];
    int offm [3] = '{99, 49, 24};

    always #25 sys_clk_i = ~sys_clk_i;

    host_ctrl_model host_u (.sys_clk_i(sys_clk_i), .slow_i(slow), .on_cmd_i(on_cmd),
        .relay_cmd_i(relay_cmd), .switch_request_o(switch_request),
        .relay_request_o(relay_request));

    quad_port_fault_manager #(.TICK_CYCLES(TICKS)) dut_u (.sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .supply_low_lockout_i(supply_low_lockout_i),
        .switch_request_i(switch_request), .relay_request_i(relay_request),
        .current_limit_i(current_limit_i), .low_current_i(low_current_i),
        .drop_high_i(drop_high_i), .fault_n_o(fault_n_o), .status_o(status_o),
        .switch_on_o(switch_on_o), .relay_on_o(relay_on_o));

    task automatic check_eq(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic hang(input string what);
        miscompares++;
        $display("unexpected %s: expected an answer, seen a timeout", what);
        close_out();
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
    endtask

    // one Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int w;
        w = 0;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        @(posedge sys_clk_i);
        while (avs_waitrequest_o !== 1'b0 && w < 16) begin
            @(posedge sys_clk_i);
            w++;
        end
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge sys_clk_i);
        if (w >= 16) hang("bus answer");
    endtask

    task automatic wait_sw(input int p, input logic v, input int lim);
        n = 0;
        while (switch_on_o[p] !== v && n < lim) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n >= lim) hang("switch change");
    endtask

    function automatic logic [31:0] ctrl(input logic en, input logic rt, input logic sel,
        input logic [1:0] dc, input logic [4:0] m);
        return {19'h0_0000, m, 3'h0, dc, sel, rt, en};
    endfunction

    initial begin
        int e;
        rows = '{'{ctrl(0, 0, 1, 0, 20), 4'h0, 4'h0, 4'hF},
            '{ctrl(0, 0, 1, 0, 20), 4'h2, 4'h0, 4'hD},
            '{ctrl(0, 0, 1, 0, 20), 4'h0, 4'h4, 4'hB},
            '{ctrl(1, 0, 1, 0, 20), 4'h0, 4'h0, 4'hF},
            '{ctrl(1, 0, 0, 0, 20), 4'h0, 4'h0, 4'h0},
            '{ctrl(0, 0, 0, 0, 20), 4'h0, 4'h0, 4'h0}};
        cyc(5);
        reset_n_i <= 1'b1;
        check_eq("outputs in reset", {fault_n_o, status_o, switch_on_o, relay_on_o}, 13'h1000);
        check_eq("waitrequest in reset", avs_waitrequest_o, 1'b1);
        cyc(1);
        bus(0, fault_pkg::CTRL_ADDR, 32'h0);
        check_eq("ctrl reset", rd, 32'h0000_0104);
        bus(1, 4'h8, 32'hFFFF_FFFF);
        bus(0, 4'h8, 32'h0);
        check_eq("unmapped read", rd, 32'h0000_0000);
        bus(0, fault_pkg::CTRL_ADDR, 32'h0);
        check_eq("ctrl after stray write", rd, 32'h0000_0104);
        bus(1, fault_pkg::CTRL_ADDR, ctrl(0, 0, 1, 0, 31));
        bus(0, fault_pkg::CTRL_ADDR, 32'h0);
        check_eq("timeout clamp high", rd, 32'h0000_1404);
        bus(1, fault_pkg::CTRL_ADDR, ctrl(0, 0, 1, 0, 0));
        bus(0, fault_pkg::CTRL_ADDR, 32'h0);
        check_eq("timeout clamp low", rd, 32'h0000_0104);
        // lane 1 alone must move only the multiplier
        avs_byteenable_i <= 4'h2;
        bus(1, fault_pkg::CTRL_ADDR, ctrl(1, 1, 0, 3, 5));
        avs_byteenable_i <= 4'hF;
        bus(0, fault_pkg::CTRL_ADDR, 32'h0);
        check_eq("lane write", rd, 32'h0000_0504);
        relay_cmd <= 4'hF;
        on_cmd <= 4'hF;
        cyc(20);
        check_eq("switches on", switch_on_o, 4'hF);
        for (int i = 0; i < 6; i++) begin
            bus(1, fault_pkg::CTRL_ADDR, rows[i].c);
            drop_high_i <= rows[i].drop;
            current_limit_i <= rows[i].lim;
            cyc(8);
            if (rows[i].c[fault_pkg::CTRL_SEL_BIT]) begin
                check_eq("status", status_o, rows[i].st);
            end else begin
                check_eq("status", status_o, rows[i].st);
            end
            check_eq("fault_n", fault_n_o, 1'b1);
        end
        drop_high_i <= 4'h0;
        current_limit_i <= 4'h8;
        for (int d = 0; d < 3; d++) begin
            bus(1, fault_pkg::CTRL_ADDR, ctrl(0, 1, 1, d[1:0], 1));
            wait_sw(3, 0, 400);
            wait_sw(3, 1, 14000);
            e = offm[d] * int'(fault_pkg::UNIT_TICKS) * TICKS;
            check_eq("retry off", n >= e - 4 && n <= e + 6, 1'b1);
        end
        current_limit_i <= 4'h0;
        bus(1, fault_pkg::CTRL_ADDR, ctrl(0, 0, 1, 2, 2));
        cyc(10);
        current_limit_i <= 4'h1;
        wait_sw(0, 0, 400);
        check_eq("timeout length", n >= 255 && n <= 272, 1'b1);
        cyc(4);
        check_eq("oc outputs", {fault_n_o, status_o, switch_on_o}, 9'h0EE);
        bus(0, fault_pkg::STATUS_ADDR, 32'h0);
        check_eq("oc latch flag", rd[8], 1'b1);
        current_limit_i <= 4'h0;
        cyc(300);
        check_eq("held off", {fault_n_o, switch_on_o[0]}, 2'b00);
        on_cmd <= 4'hE;
        cyc(8);
        check_eq("oc cleared", fault_n_o, 1'b1);
        on_cmd <= 4'hF;
        cyc(100);
        check_eq("waits off time", switch_on_o[0], 1'b0);
        wait_sw(0, 1, 6500);
        bus(1, fault_pkg::CTRL_ADDR, ctrl(1, 0, 0, 2, 1));
        slow <= 1'b1;
        on_cmd <= 4'hD;
        wait_sw(1, 0, 20);
        on_cmd <= 4'hF;
        wait_sw(1, 1, 100);
        // low current during the arming delay must not trip the port
        low_current_i <= 4'h2;
        cyc(17900);
        check_eq("not yet armed", {fault_n_o, switch_on_o[1]}, 2'b11);
        low_current_i <= 4'h0;
        cyc(200);
        low_current_i <= 4'h2;
        wait_sw(1, 0, 700);
        check_eq("open delay", n >= 510 && n <= 530, 1'b1);
        cyc(4);
        check_eq("open outputs", {fault_n_o, status_o}, 5'h02);
        bus(1, fault_pkg::CTRL_ADDR, ctrl(0, 0, 0, 2, 1));
        cyc(2);
        check_eq("open hidden", status_o, 4'h0);
        bus(1, fault_pkg::CTRL_ADDR, ctrl(1, 0, 0, 2, 1));
        low_current_i <= 4'h0;
        on_cmd <= 4'hD;
        cyc(10);
        check_eq("open cleared", {fault_n_o, status_o}, 5'h10);
        supply_low_lockout_i <= 1'b1;
        cyc(8);
        check_eq("lockout", {fault_n_o, switch_on_o, relay_on_o}, 9'h000);
        bus(0, fault_pkg::STATUS_ADDR, 32'h0);
        check_eq("lockout flag", rd[16], 1'b1);
        supply_low_lockout_i <= 1'b0;
        cyc(10);
        check_eq("after lockout", {fault_n_o, relay_on_o}, 5'h1F);
        close_out();
    end
endmodule
